// [inc/spindle_consts.svh]
// offsets, field positions, reset values and timing counts of the spindle block
// assumes inclusion by spindle_pkg, spindle_ctrl and the bench
`ifndef SPINDLE_CONSTS_SVH
`define SPINDLE_CONSTS_SVH
// word index inside one spindle bank (bank stride 32 words)
`define W_CTRL    5'h00
`define W_DIRECT  5'h01
`define W_OVR     5'h02
`define W_CODE    5'h03
`define W_STAT    5'h04
`define W_CMD     5'h05
`define W_FB      5'h06
`define W_ANG     5'h07
`define W_PRM     5'h08
`define W_LAST    5'h10
`define BANK_LSB  7
// parameter words, index from W_PRM
`define PRM_N     9
`define P_SET     0
`define P_INIT    1
`define P_MAX     2
`define P_ACC     3
`define P_SCV     4
`define P_OFS     5
`define P_ZTOL    6
`define P_MTOL    7
`define P_OTOL    8
// control word bits
`define C_FWD     0
`define C_REV     1
`define C_ORI     2
`define C_SRC     3
`define C_FIN     4
// setting word fields
`define S_TYPE    1:0
`define S_REF     4
`define S_UNIT    7
// values
`define OVR_MAX   7'h78
`define OVR_RST   7'h64
`define PCT_DIV   64'h0000_0000_0000_0064
`define DIRECT_M  32'h7FFF_FFFF
`define DEG_FULL  32'h0000_8CA0
`define DAC_FULL  64'h0000_0000_0000_7FFF
`define RESP_OK   2'b00
`define RESP_ERR  2'b10
// timing: ramp tick of 1 ms at a 10 ns clock
`define TICK_NS   1000000
`define CLK_NS    10
`endif

// [inc/spindle_pkg.sv]
// types shared by the spindle control block and its bench
// assumes spindle_consts.svh on the include path
`include "spindle_consts.svh"
package spindle_pkg;
  typedef enum logic [1:0] {CT_COMM = 2'd0, CT_RSVD = 2'd1, CT_ANALOG = 2'd2} ctype_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_WAIT = 2'b01, RD_RESP = 2'b11} rd_state_t;
  typedef logic [`PRM_N-1:0][31:0] prm_t;
  // encoder side of one spindle
  typedef struct packed {
    logic        index;
    logic [31:0] speed;
    logic [31:0] angle;
  } enc_t;
  // drive side of one spindle
  typedef struct packed {
    logic        fwd;
    logic        rev;
    logic        orient;
    logic        analog;
    logic [31:0] speed_ref;
    logic [31:0] angle_target;
  } drive_t;
  // live state of one spindle
  typedef struct packed {
    logic        fwd;
    logic        rev;
    logic        orient;
    logic        src;
    logic [31:0] direct;
    logic [6:0]  ovr;
    logic [31:0] code;
    logic        exec;
    logic [31:0] cmd;
    logic [31:0] ramp;
    logic [31:0] slope;
    logic [31:0] fb;
    logic [31:0] ang;
    logic [31:0] zero_pos;
    logic        run_prev;
    logic        tick;
    logic        match;
    logic        zero;
    logic        done;
    logic        reach;
  } spin_t;
endpackage : spindle_pkg

// [logic/spindle_param_mem.sv]
// parameter store, one wide word per spindle, bit-masked write
// assumes one clock; unwritten entries read as zero
`timescale 1ns/10ps
module spindle_param_mem #(
  parameter int WIDTH = 288,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_mask,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] written_reg;
  logic [WIDTH-1:0] old_word;

  initial
  begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) $error("spindle_param_mem: bad depth");
  end

  assign old_word = written_reg[wr_addr] ? mem[wr_addr] : '0;

  always_ff @(posedge clock)
  begin
    if (wr_en) mem[wr_addr] <= (old_word & ~wr_mask) | (wr_data & wr_mask);
  end

  // the written map hides the array's power-up contents
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      written_reg <= '0;
      rd_data     <= '0;
    end
    else
    begin
      if (wr_en) written_reg[wr_addr] <= 1'b1;
      rd_data <= written_reg[rd_addr] ? mem[rd_addr] : '0;
    end
  end
endmodule : spindle_param_mem

// [logic/spindle_ctrl.sv]
// spindle run, orient and speed-source control for NSP spindles, AXI4-Lite slave
// assumes encoder inputs asynchronous to clock; parameters live in spindle_param_mem
//
// How it works
// - run request rotates spindle at programmed speed
// - orient zeroes at index, moves to offset, stops
// - speed match drops on command change, reasserts
// - speed match also when command zero, at rest
// - match when error within tolerance, inclusive
// - zero speed when speed within zero tolerance
// - zero speed clears on run start, nonzero command
// - orient done after settling, cleared on rotation
// - source relay picks direct speed or program
// - direct speed 0..2^31-1, masked to 31 bits, immediate
// - override 0..120 scales program speed, clamped, immediate
// - speed code writes data word and command
// - speed feedback tracks measured speed while rotating
// - angle feedback tracks measured angle while rotating
// - control type 0 comm, 1 reserved, 2 analog
// - reference from program or initial speed parameter
// - match tolerance in rpm or percent of command
// - max speed is ceiling or analog scale
// - ramps follow accel time, shaped by S-curve time
// - orient reach when angle error within tolerance
`timescale 1ns/10ps
`include "spindle_consts.svh"
module spindle_ctrl
  import spindle_pkg::*;
#(
  parameter int NSP         = 8,
  parameter int ADDR_W      = 10,
  parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  // axi4-lite write
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // axi4-lite read
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // encoders and drives
  input  wire spindle_pkg::enc_t    enc   [NSP],
  output spindle_pkg::drive_t       drive [NSP]
);
  localparam int SW = (NSP > 1) ? $clog2(NSP) : 1;
  localparam int PW = `PRM_N * 32;

  initial
  begin
    if (NSP < 1 || ADDR_W < `BANK_LSB + SW || TICK_CYCLES < 1) $error("spindle_ctrl: bad params");
  end

  typedef struct packed {
    spin_t     [NSP-1:0] sp;
    enc_t      [NSP-1:0] enc1;
    enc_t      [NSP-1:0] enc2;
    logic      [NSP-1:0] idx_prev;
    drive_t    [NSP-1:0] drv;
    logic      [31:0]    tick_cnt;
    logic      [SW-1:0]  sched;
    logic                vis_v;
    logic      [SW-1:0]  vis_idx;
    logic                aw_have;
    logic                w_have;
    logic [ADDR_W-1:0]   aw_addr;
    logic      [31:0]    w_data;
    logic      [3:0]     w_strb;
    logic                bvalid;
    logic      [1:0]     bresp;
    rd_state_t           rd;
    logic [ADDR_W-1:0]   ar_addr;
    logic      [31:0]    rdata;
    logic      [1:0]     rresp;
  } state_t;

  state_t            st_reg;
  state_t            st_next;
  prm_t              prm;
  logic [PW-1:0]     prm_bits;
  logic              ar_fire;
  logic [SW-1:0]     rd_sel;
  logic              wr_go;
  logic [SW-1:0]     w_sp;
  logic [4:0]        w_wi;
  logic              w_ok;
  logic [31:0]       w_mrg;
  logic              mem_we;
  logic [PW-1:0]     mem_mask;
  logic [PW-1:0]     mem_data;
  logic [SW-1:0]     vk;
  spin_t             s;
  logic              run;
  logic              start;
  logic [31:0]       prog;
  logic [31:0]       eff;
  logic [31:0]       tgt;
  logic [31:0]       lim;
  logic [31:0]       jerk;
  logic [31:0]       slp;
  logic [31:0]       meas;
  logic [31:0]       angn;
  logic [31:0]       tol;
  logic              zero_w;

  function automatic logic [31:0] absd(input logic [31:0] a, input logic [31:0] b);
    absd = (a >= b) ? a - b : b - a;
  endfunction : absd

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // handshakes and parameter store
  assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_have && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.rd == RD_IDLE;
  assign s_axi_rvalid  = st_reg.rd == RD_RESP;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  // a bus read steals the store's read port for one cycle; the sweep resumes after
  assign rd_sel   = ar_fire ? s_axi_araddr[`BANK_LSB +: SW] : st_reg.sched;
  assign wr_go    = st_reg.aw_have && st_reg.w_have;
  assign w_sp     = st_reg.aw_addr[`BANK_LSB +: SW];
  assign w_wi     = st_reg.aw_addr[6:2];
  assign w_ok     = (32'(st_reg.aw_addr >> `BANK_LSB) < NSP) && (w_wi <= `W_LAST);
  assign mem_we   = wr_go && w_ok && (w_wi >= `W_PRM);
  assign mem_data = {`PRM_N{st_reg.w_data}};
  assign prm      = prm_t'(prm_bits);
  assign vk       = st_reg.vis_idx;

  always_comb
  begin
    mem_mask = '0;
    for (int b = 0; b < 4; b++)
    begin
      mem_mask[b*8 +: 8] = {8{st_reg.w_strb[b]}};
    end
    mem_mask = mem_mask << (32 * 32'(w_wi - `W_PRM));
  end

  spindle_param_mem #(
    .WIDTH (PW),
    .DEPTH (NSP),
    .AW    (SW)
  ) u_prm (
    .clock   (clock),
    .reset_n (reset_n),
    .wr_en   (mem_we),
    .wr_addr (w_sp),
    .wr_mask (mem_mask),
    .wr_data (mem_data),
    .rd_addr (rd_sel),
    .rd_data (prm_bits)
  );

  generate
    for (genvar g = 0; g < NSP; g++)
    begin : g_drv
      assign drive[g] = st_reg.drv[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_next = st_reg;
    s = st_reg.sp[vk];
    run = s.fwd || s.rev;
    start = run && !s.run_prev;
    prog = '0; eff = '0; tgt = '0; lim = '0; jerk = '0; slp = '0;
    meas = st_reg.enc2[vk].speed;
    angn = '0; tol = '0; zero_w = 1'b0;
    // two-flop synchronisers, index capture and ramp tick per spindle
    st_next.tick_cnt = (st_reg.tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : st_reg.tick_cnt + 1'b1;
    for (int i = 0; i < NSP; i++)
    begin
      st_next.enc1[i] = enc[i];
      st_next.enc2[i] = st_reg.enc1[i];
      st_next.idx_prev[i] = st_reg.enc2[i].index;
      if (st_reg.enc2[i].index && !st_reg.idx_prev[i])
        st_next.sp[i].zero_pos = st_reg.enc2[i].angle;
      if (st_reg.tick_cnt == '0) st_next.sp[i].tick = 1'b1;
    end
    // round-robin visit of one spindle; its parameters arrive this cycle
    st_next.vis_v = !ar_fire;
    st_next.vis_idx = st_reg.sched;
    if (!ar_fire)
      st_next.sched = (32'(st_reg.sched) == NSP - 1) ? '0 : st_reg.sched + 1'b1;
    if (st_reg.vis_v)
    begin
      prog = s.code;
      if (prm[`P_SET][`S_REF]) prog = prm[`P_INIT];
      eff = 32'((64'(prog) * 64'(s.ovr)) / `PCT_DIV);
      if (s.src) eff = s.direct;
      if (eff > prm[`P_MAX]) eff = prm[`P_MAX];
      st_next.sp[vk].cmd = eff;
      tgt = (run && !s.orient) ? eff : '0;
      if (s.tick)
      begin
        // s-curve only softens the start of a ramp; arrival is abrupt
        lim = (prm[`P_ACC] == '0) ? prm[`P_MAX] : prm[`P_MAX] / prm[`P_ACC];
        if (lim == '0) lim = 32'h0000_0001;
        jerk = (prm[`P_SCV] == '0) ? lim : lim / prm[`P_SCV];
        if (jerk == '0) jerk = 32'h0000_0001;
        slp = (s.slope >= lim - jerk) ? lim : s.slope + jerk;
        if (absd(tgt, s.ramp) <= slp)
        begin
          st_next.sp[vk].ramp = tgt;
          st_next.sp[vk].slope = '0;
        end
        else
        begin
          st_next.sp[vk].ramp = (tgt > s.ramp) ? s.ramp + slp : s.ramp - slp;
          st_next.sp[vk].slope = slp;
        end
        st_next.sp[vk].tick = st_reg.tick_cnt == '0;
      end
      // angle relative to the last index edge, in hundredths of a degree
      angn = (st_reg.enc2[vk].angle >= s.zero_pos) ? st_reg.enc2[vk].angle - s.zero_pos
           : st_reg.enc2[vk].angle + `DEG_FULL - s.zero_pos;
      if (run || s.orient)
      begin
        st_next.sp[vk].fb = meas;
        st_next.sp[vk].ang = angn;
      end
      st_next.sp[vk].run_prev = run;
      zero_w = meas <= prm[`P_ZTOL];
      st_next.sp[vk].zero = zero_w && eff == '0 && !start;
      tol = prm[`P_SET][`S_UNIT] ? 32'((64'(eff) * 64'(prm[`P_MTOL])) / `PCT_DIV)
          : prm[`P_MTOL];
      st_next.sp[vk].match = (eff == s.cmd) && ((run && absd(meas, eff) <= tol)
                           || (eff == '0 && st_next.sp[vk].zero));
      st_next.sp[vk].reach = s.orient && absd(angn, prm[`P_OFS]) <= prm[`P_OTOL];
      if (start)
        st_next.sp[vk].done = 1'b0;
      else if (s.orient && st_next.sp[vk].reach && zero_w)
        st_next.sp[vk].done = 1'b1;
      st_next.drv[vk].fwd = s.fwd;
      st_next.drv[vk].rev = s.rev && !s.fwd;
      st_next.drv[vk].orient = s.orient && !st_next.sp[vk].done;
      st_next.drv[vk].angle_target = prm[`P_OFS];
      st_next.drv[vk].analog = prm[`P_SET][`S_TYPE] == CT_ANALOG;
      case (ctype_t'(prm[`P_SET][`S_TYPE]))
        CT_COMM:   st_next.drv[vk].speed_ref = st_next.sp[vk].ramp;
        CT_ANALOG: st_next.drv[vk].speed_ref = (prm[`P_MAX] == '0) ? '0
                 : 32'((64'(st_next.sp[vk].ramp) * `DAC_FULL) / 64'(prm[`P_MAX]));
        default:   st_next.drv[vk].speed_ref = '0;
      endcase
    end
    // write channel: address and data in either order, then respond
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
    w_mrg = '0;
    if (wr_go)
    begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = w_ok ? `RESP_OK : `RESP_ERR;
      if (w_ok)
      begin
        case (w_wi)
          `W_CTRL:
          begin
            w_mrg = merge({28'h000_0000, st_reg.sp[w_sp].src, st_reg.sp[w_sp].orient,
                           st_reg.sp[w_sp].rev, st_reg.sp[w_sp].fwd}, st_reg.w_data,
                          st_reg.w_strb);
            st_next.sp[w_sp].fwd = w_mrg[`C_FWD];
            st_next.sp[w_sp].rev = w_mrg[`C_REV];
            st_next.sp[w_sp].orient = w_mrg[`C_ORI];
            st_next.sp[w_sp].src = w_mrg[`C_SRC];
            if (w_mrg[`C_FIN]) st_next.sp[w_sp].exec = 1'b0;
          end
          `W_DIRECT:
          begin
            w_mrg = merge(st_reg.sp[w_sp].direct, st_reg.w_data, st_reg.w_strb);
            st_next.sp[w_sp].direct = w_mrg & `DIRECT_M;
          end
          `W_OVR:
          begin
            w_mrg = merge({25'h000_0000, st_reg.sp[w_sp].ovr}, st_reg.w_data, st_reg.w_strb);
            st_next.sp[w_sp].ovr = (w_mrg > 32'(`OVR_MAX)) ? `OVR_MAX : w_mrg[6:0];
          end
          `W_CODE:
          begin
            w_mrg = merge(st_reg.sp[w_sp].code, st_reg.w_data, st_reg.w_strb);
            st_next.sp[w_sp].code = w_mrg;
            st_next.sp[w_sp].cmd = w_mrg;
            st_next.sp[w_sp].exec = 1'b1;
            // a new code is a command change even when a visit lands in the same cycle
            st_next.sp[w_sp].match = 1'b0;
          end
          `W_PRM + 5'(`P_INIT):
          begin
            st_next.sp[w_sp].code = merge(st_reg.sp[w_sp].code, st_reg.w_data,
                                          st_reg.w_strb);
          end
          default:
          begin
            w_mrg = '0;
          end
        endcase
      end
    end
    // read channel: one wait cycle for the parameter store
    case (st_reg.rd)
      RD_IDLE:
      begin
        if (ar_fire)
        begin
          st_next.rd = RD_WAIT;
          st_next.ar_addr = s_axi_araddr;
        end
      end
      RD_WAIT:
      begin
        st_next.rd = RD_RESP;
        st_next.rresp = `RESP_OK;
        st_next.rdata = '0;
        if (32'(st_reg.ar_addr >> `BANK_LSB) >= NSP || st_reg.ar_addr[6:2] > `W_LAST)
          st_next.rresp = `RESP_ERR;
        else if (st_reg.ar_addr[6:2] >= `W_PRM)
          st_next.rdata = prm[st_reg.ar_addr[6:2] - `W_PRM];
        else
        begin
          case (st_reg.ar_addr[6:2])
            `W_CTRL:   st_next.rdata = {28'h000_0000, st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].src,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].orient,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].rev,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].fwd};
            `W_DIRECT: st_next.rdata = st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].direct;
            `W_OVR:    st_next.rdata = {25'h000_0000, st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].ovr};
            `W_CODE:   st_next.rdata = st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].code;
            `W_STAT:   st_next.rdata = {27'h000_0000, st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].exec,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].reach,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].done,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].zero,
                         st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].match};
            `W_CMD:    st_next.rdata = st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].cmd;
            `W_FB:     st_next.rdata = st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].fb;
            default:   st_next.rdata = st_reg.sp[st_reg.ar_addr[`BANK_LSB +: SW]].ang;
          endcase
        end
      end
      RD_RESP:
      begin
        if (s_axi_rready) st_next.rd = RD_IDLE;
      end
      default:
      begin
        st_next.rd = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
      for (int i = 0; i < NSP; i++)
      begin
        st_reg.sp[i].ovr <= `OVR_RST;
      end
    end
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // a speed code lands raw in the command word until the next visit clamps it
  a_cmd_clamp: assert property (st_reg.vis_v && !(wr_go && w_ok && w_wi == `W_CODE) |=>
    st_reg.sp[$past(vk)].cmd <= $past(prm[`P_MAX])) else $error("command above max");
  a_match_drop: assert property (st_reg.vis_v && st_next.sp[vk].cmd != s.cmd
    |=> !st_reg.sp[$past(vk)].match) else $error("match held over command change");
  a_zero_start: assert property (st_reg.vis_v && start
    |=> !st_reg.sp[$past(vk)].zero) else $error("zero speed held at run start");
  a_done_cause: assert property (st_reg.vis_v && !s.done && st_next.sp[vk].done
    |-> s.orient && st_next.sp[vk].reach) else $error("done without orient reach");
  a_ovr_range: assert property (st_reg.sp[vk].ovr <= `OVR_MAX)
    else $error("override above limit");
  a_direct_top: assert property (!st_reg.sp[vk].direct[31])
    else $error("direct speed out of range");
  a_code_exec: assert property (wr_go && w_ok && w_wi == `W_CODE && st_reg.w_strb == 4'hF
    |=> st_reg.sp[$past(w_sp)].exec && st_reg.sp[$past(w_sp)].cmd == $past(st_reg.w_data))
    else $error("speed code not taken");
  a_fb_hold: assert property (st_reg.vis_v && !run && !s.orient
    |=> st_reg.sp[$past(vk)].fb == $past(st_reg.sp[vk].fb))
    else $error("feedback moved while idle");
  a_read_lat: assert property (ar_fire |-> !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer not two cycles after address");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  c_match_rise: cover property (st_reg.vis_v && !s.match && st_next.sp[vk].match);
  c_done_rise: cover property (st_reg.vis_v && !s.done && st_next.sp[vk].done);
  c_write: cover property (wr_go && w_ok);
  c_read: cover property (ar_fire);
endmodule : spindle_ctrl

// [tb/spindle_drive_model.sv]
// drive and encoder model of one spindle
// assumes registered drive outputs; slow gives a gentle speed slew
`timescale 1ns/10ps
module spindle_drive_model
  import spindle_pkg::*;
(
  // clock and reset
  input  wire logic   clock,
  input  wire logic   reset_n,
  // block side
  input  wire drive_t drv,
  input  wire logic   slow,
  output enc_t        enc
);
  logic [31:0] tgt;
  logic [31:0] stp;
  assign tgt = (drv.fwd || drv.rev) ? drv.speed_ref : 32'h0000_0000;
  assign stp = slow ? 32'h0000_0004 : 32'h0000_0040;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      enc <= '0;
    else
    begin
      if (enc.speed + stp < tgt)
        enc.speed <= enc.speed + stp;
      else if (enc.speed > tgt + stp)
        enc.speed <= enc.speed - stp;
      else
        enc.speed <= tgt;
      // orient crawls eight counts a cycle; index wide enough to be synced
      if (enc.speed != 0 || drv.orient)
        enc.angle <= (enc.angle >= 32'd35990) ? 32'h0 : enc.angle + (drv.orient ? 8 : 1);
      enc.index <= enc.angle < 32;
    end
endmodule : spindle_drive_model

// [tb/spindle_speed_orient_control_tb.sv]
// self-checking bench: axi4-lite master, two modelled spindles
// assumes spindle_drive_model; ramp tick shortened to 20 cycles
`timescale 1ns/10ps
`include "spindle_consts.svh"
module spindle_speed_orient_control_tb;
  import spindle_pkg::*;
  localparam int NSP = 2;
  logic clock = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, code, ovr;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  enc_t enc [NSP];
  drive_t drive [NSP];
  int n_fail = 0, checks = 0, k, i;
  always #5 clock = ~clock;
  spindle_ctrl #(.NSP(NSP), .TICK_CYCLES(20)) spindle_ctrl_inst (.*);
  for (genvar g = 0; g < NSP; g++)
  begin : g_sp
    spindle_drive_model spindle_drive_model_inst (.clock(clock), .reset_n(reset_n),
      .drv(drive[g]), .slow(g[0]), .enc(enc[g]));
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] adr(input int s, input int w);
    return 10'(s * 128 + w * 4);
  endfunction : adr
  function automatic logic [31:0] ecmd(input logic [31:0] c, o, m);
    logic [63:0] p;
    p = 64'(c) * 64'(o) / 64'd100;
    return (p > 64'(m)) ? m : p[31:0];
  endfunction : ecmd
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic hang;
    n_fail++;
    $display("Error %0t: wait ran out", $time);
    wrap_up;
  endtask : hang
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int j = 0; j < 100; j++)
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        return;
      end
    end
    hang;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int j = 0; j < 100; j++)
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 0;
      if (s_axi_rvalid)
      begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
        return;
      end
    end
    hang;
  endtask : rd
  // polls a status bit; orient crawl needs the long bound
  task automatic flag(input int s, b, input logic v);
    for (int j = 0; j < 2000; j++)
    begin
      rd(adr(s, `W_STAT), d, r);
      if (d[b] === v)
        return;
    end
    hang;
  endtask : flag
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hc6a3));
    repeat (20) @(posedge clock);
    reset_n <= 1;
    rd(adr(0, `W_OVR), d, r);
    chk(d, 32'h0000_0064);
    wr(adr(1, `W_OVR), 32'h0000_008C);
    chk({30'h0, r}, 32'h0000_0000);
    rd(adr(1, `W_OVR), d, r);
    chk(d, 32'h0000_0078);
    rd(adr(0, 17), d, r);
    chk({30'h0, r}, 32'h0000_0002);
    wr(adr(0, 17), 32'h0000_0001);
    chk({30'h0, r}, 32'h0000_0002);
    $display("register test done");
    for (k = 0; k < NSP; k++)
    begin
      wr(adr(k, `W_PRM + `P_MAX), 32'h0000_1388);
      wr(adr(k, `W_PRM + `P_ZTOL), 32'h0000_000A);
      wr(adr(k, `W_PRM + `P_MTOL), 32'h0000_0014);
      wr(adr(k, `W_PRM + `P_OFS), 32'h0000_03E8);
      wr(adr(k, `W_PRM + `P_OTOL), 32'h0000_01F4);
    end
    for (i = 0; i < 8; i++)
    begin
      code = (i == 0) ? 32'h0000_2710 : $urandom % 9000;
      ovr = 10 * ($urandom % 13);
      wr(adr(0, `W_CODE), code);
      wr(adr(0, `W_OVR), ovr);
      repeat (8) @(posedge clock);
      rd(adr(0, `W_CMD), d, r);
      chk(d, ecmd(code, ovr, 5000));
    end
    rd(adr(0, `W_STAT), d, r);
    chk(d[4], 1);
    $display("override test done");
    wr(adr(0, `W_CTRL), 32'h0000_0008);
    for (i = 0; i < 4; i++)
    begin
      code = (i == 0) ? 32'h7FFF_FFFF : $urandom % 7000;
      wr(adr(0, `W_DIRECT), code);
      repeat (8) @(posedge clock);
      rd(adr(0, `W_CMD), d, r);
      chk(d, ecmd(code, 100, 5000));
    end
    $display("direct test done");
    for (k = 0; k < NSP; k++)
    begin
      wr(adr(k, `W_DIRECT), 32'h0000_0BB8);
      wr(adr(k, `W_CTRL), 32'h0000_0009);
      flag(k, 0, 1);
      rd(adr(k, `W_STAT), d, r);
      chk(d[1], 0);
      rd(adr(k, `W_FB), d, r);
      chk(d >= 2980 && d <= 3020, 1);
      chk(drive[k].fwd, 1);
      chk(drive[k].speed_ref, 32'h0000_0BB8);
      wr(adr(k, `W_DIRECT), 32'h0000_07D0);
      flag(k, 0, 1);
      wr(adr(k, `W_DIRECT), 32'h0000_0000);
      wr(adr(k, `W_CTRL), 32'h0000_0008);
      flag(k, 1, 1);
      flag(k, 0, 1);
    end
    wr(adr(1, `W_PRM + `P_SET), 32'h0000_0002);
    repeat (8) @(posedge clock);
    chk(drive[1].analog, 1);
    $display("run test done");
    wr(adr(0, `W_CTRL), 32'h0000_000C);
    flag(0, 2, 1);
    rd(adr(0, `W_ANG), d, r);
    chk(d >= 500 && d <= 1500, 1);
    chk(drive[0].orient, 0);
    wr(adr(0, `W_CTRL), 32'h0000_001C);
    rd(adr(0, `W_STAT), d, r);
    chk(d[4], 0);
    wr(adr(0, `W_DIRECT), 32'h0000_03E8);
    wr(adr(0, `W_CTRL), 32'h0000_000A);
    flag(0, 2, 0);
    chk(drive[0].rev, 1);
    $display("orient test done");
    wrap_up;
  end
endmodule : spindle_speed_orient_control_tb
